// ---- mmt_pkg.sv ----
// Package: register map, field positions, reset values and mode codes for the capture timer
package mmt_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_COUNT     = 8'h04;
    localparam logic [7:0] ADDR_RELOAD_A  = 8'h08;
    localparam logic [7:0] ADDR_RELOAD_B  = 8'h0c;
    localparam logic [7:0] ADDR_FAST_CTRL = 8'h10;
    localparam logic [7:0] ADDR_SYS       = 8'h14;

    // ------------------------------------------------------------
    // Timer control field positions
    // ------------------------------------------------------------
    localparam int CTRL_RUN  = 0;
    localparam int CTRL_MLOW = 1;
    localparam int CTRL_MMID = 2;
    localparam int CTRL_MHI  = 3;
    localparam int CTRL_PNDA = 4;
    localparam int CTRL_ENA  = 5;
    localparam int CTRL_PNDB = 6;
    localparam int CTRL_ENB  = 7;

    // Fast timer control field positions
    localparam int FAST_SEL2 = 0;
    localparam int FAST_SEL3 = 1;
    localparam int FAST_DOZE = 7;

    // System field positions: doze level, clock mode
    localparam int SYS_DOZE  = 0;
    localparam int SYS_CMODE = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  FAST_RESET   = 8'h00;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [2:0]  SYS_RESET    = 3'h0;

    // Instruction cycle is this many reference clocks
    localparam int TC_DIV = 10;

    // ------------------------------------------------------------
    // Mode codes (high, mid, low)
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_PWM       = 3'h4;
    localparam logic [2:0] MODE_PWM_TOG   = 3'h5;
    localparam logic [2:0] MODE_EVT_RISE  = 3'h0;
    localparam logic [2:0] MODE_EVT_FALL  = 3'h1;

    // System clock modes
    typedef enum logic [1:0] {
        CLK_HIGH_SPEED,
        CLK_DUAL,
        CLK_LOW_SPEED
    } clk_mode_e;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- pin_sync.sv ----
// Three-stage synchroniser with edge detection for one timer pin
`timescale 1ns/1ps
module pin_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      rise,
    output logic      fall,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    // s1 feeds only s2; change counts when s2 and s3 agree on a new level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end

    assign rise = (s2 == s3) && s3 && !level;
    assign fall = (s2 == s3) && !s3 && level;
endmodule

// ---- multi_mode_timer_capture.sv ----
// Top: 16-bit multi-mode timer with capture, pulse-width and event-count modes, AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps

module multi_mode_timer_capture #(
    parameter int CNT_W = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        fast_tick,
    input  wire logic        slow_tick,
    input  wire logic        timer_pin_a,
    input  wire logic        timer_pin_b,
    output logic             pulse_out,
    output logic             irq_a,
    output logic             irq_b,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]       ctrl;
    logic [7:0]       fast_timer_ctrl;
    logic [2:0]       sys;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] capture_reload_reg_a;
    logic [CNT_W-1:0] capture_reload_reg_b;
    logic             reload_from_b;
    logic [3:0]       tc_cnt;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire       mode_select_high = ctrl[mmt_pkg::CTRL_MHI];
    wire       mode_select_mid  = ctrl[mmt_pkg::CTRL_MMID];
    wire       mode_select_low  = ctrl[mmt_pkg::CTRL_MLOW];
    wire       run_or_underflow_flag = ctrl[mmt_pkg::CTRL_RUN];
    wire       pending_flag_a   = ctrl[mmt_pkg::CTRL_PNDA];
    wire       pending_flag_b   = ctrl[mmt_pkg::CTRL_PNDB];
    wire       irq_enable_a     = ctrl[mmt_pkg::CTRL_ENA];
    wire       irq_enable_b     = ctrl[mmt_pkg::CTRL_ENB];
    wire [2:0] mode = {mode_select_high, mode_select_mid, mode_select_low};

    wire is_capture = mode_select_mid;
    wire is_pwm     = !mode_select_mid && mode_select_high;
    wire is_event   = !mode_select_mid && !mode_select_high;
    wire toggle_en  = (mode == mmt_pkg::MODE_PWM_TOG);

    wire second_timer_fast_select = fast_timer_ctrl[mmt_pkg::FAST_SEL2];
    wire doze_run_enable          = fast_timer_ctrl[mmt_pkg::FAST_DOZE];
    wire doze                     = sys[mmt_pkg::SYS_DOZE];
    wire [1:0] clk_mode           = sys[2:1];

    // ------------------------------------------------------------
    // Clocking: processor clock stands still in doze
    // ------------------------------------------------------------
    wire tc_tick   = (tc_cnt == 4'(mmt_pkg::TC_DIV - 1));
    wire proc_tick = (clk_mode == 2'(mmt_pkg::CLK_LOW_SPEED)) ? slow_tick : fast_tick;
    // Doze keeps the timer alive only with both bits set and toggle mode off; clock per system mode
    wire doze_ok   = second_timer_fast_select && doze_run_enable &&
                     !toggle_en;
    wire doze_tick = (clk_mode == 2'(mmt_pkg::CLK_LOW_SPEED)) ? slow_tick : fast_tick;
    // In doze the instruction-cycle clock is unavailable: slow clock in low-speed mode, else fast clock
    wire rate_tick = doze ? (doze_ok && doze_tick) :
                     (second_timer_fast_select ? proc_tick : (proc_tick && tc_tick));

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    wire a_rise;
    wire a_fall;
    wire b_rise;
    wire b_fall;

    pin_sync u_sync_a (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (timer_pin_a),
        .rise    (a_rise),
        .fall    (a_fall),
        .level   ()
    );

    pin_sync u_sync_b (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (timer_pin_b),
        .rise    (b_rise),
        .fall    (b_fall),
        .level   ()
    );

    // Pins only act while the timer clock is alive
    wire active  = !doze || doze_ok;
    wire edge_a  = active && (mode_select_low ? a_fall : a_rise);
    wire edge_b  = active && (is_capture && mode_select_high ? b_fall : b_rise);
    wire trig_a  = is_capture && edge_a;
    wire trig_b  = is_capture && edge_b;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    wire cnt_step  = is_capture ? rate_tick :
                     (run_or_underflow_flag && (is_event ? edge_a : rate_tick));
    wire underflow = cnt_step && (count == '0);
    wire [CNT_W-1:0] next_count = !underflow ? count - 1'b1 :
                     (is_pwm ? (reload_from_b ? capture_reload_reg_b : capture_reload_reg_a)
                             : count - 1'b1);

    // Hardware set events per flag
    wire set_pnda = trig_a || (is_event && underflow) ||
                    (is_pwm && underflow && !reload_from_b);
    wire set_pndb = trig_b || (is_event && b_rise && active) ||
                    (is_pwm && underflow && reload_from_b);
    wire set_unf  = is_capture && underflow;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire do_write = aw_held && w_held;
    wire wr_ctrl  = do_write && (aw_addr == mmt_pkg::ADDR_CTRL) && w_strb[0];
    wire wr_cnt   = do_write && (aw_addr == mmt_pkg::ADDR_COUNT);
    wire wr_ra    = do_write && (aw_addr == mmt_pkg::ADDR_RELOAD_A);
    wire wr_rb    = do_write && (aw_addr == mmt_pkg::ADDR_RELOAD_B);
    wire wr_fast  = do_write && (aw_addr == mmt_pkg::ADDR_FAST_CTRL) && w_strb[0];
    wire wr_sys   = do_write && (aw_addr == mmt_pkg::ADDR_SYS) && w_strb[0];

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == mmt_pkg::ADDR_CTRL) || (a == mmt_pkg::ADDR_COUNT) ||
                  (a == mmt_pkg::ADDR_RELOAD_A) || (a == mmt_pkg::ADDR_RELOAD_B) ||
                  (a == mmt_pkg::ADDR_FAST_CTRL) || (a == mmt_pkg::ADDR_SYS);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    wire [7:0] wctrl = w_data[7:0];
    // Whole-byte write: hardware set wins over a written zero on pending bits
    wire [7:0] next_ctrl_sw = wr_ctrl ? wctrl : ctrl;
    wire [7:0] next_ctrl = {next_ctrl_sw[7], next_ctrl_sw[6] | set_pndb,
                            next_ctrl_sw[5], next_ctrl_sw[4] | set_pnda,
                            next_ctrl_sw[3:1], next_ctrl_sw[0] | set_unf};

    wire [31:0] rd_mux =
        (s_axi_araddr == mmt_pkg::ADDR_CTRL)      ? {24'h000000, ctrl} :
        (s_axi_araddr == mmt_pkg::ADDR_COUNT)     ? {16'h0000, count} :
        (s_axi_araddr == mmt_pkg::ADDR_RELOAD_A)  ? {16'h0000, capture_reload_reg_a} :
        (s_axi_araddr == mmt_pkg::ADDR_RELOAD_B)  ? {16'h0000, capture_reload_reg_b} :
        (s_axi_araddr == mmt_pkg::ADDR_FAST_CTRL) ? {24'h000000, fast_timer_ctrl} :
        (s_axi_araddr == mmt_pkg::ADDR_SYS)       ? {29'h0, sys} : 32'h00000000;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= mmt_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= mmt_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_ok(aw_addr) ? mmt_pkg::RESP_OKAY : mmt_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= addr_ok(s_axi_araddr) ? mmt_pkg::RESP_OKAY : mmt_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Timer registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl                 <= mmt_pkg::CTRL_RESET;
            fast_timer_ctrl      <= mmt_pkg::FAST_RESET;
            sys                  <= mmt_pkg::SYS_RESET;
            count                <= mmt_pkg::COUNT_RESET;
            capture_reload_reg_a <= mmt_pkg::RELOAD_RESET;
            capture_reload_reg_b <= mmt_pkg::RELOAD_RESET;
            reload_from_b        <= 1'b0;
            tc_cnt               <= 4'h0;
            pulse_out            <= 1'b0;
        end else begin
            tc_cnt <= tc_tick ? 4'h0 : tc_cnt + 4'h1;
            ctrl   <= next_ctrl;
            if (wr_fast) begin
                // Only bits 7, 1, 0 exist
                fast_timer_ctrl <= {w_data[7], 5'h00, w_data[1:0]};
            end
            if (wr_sys) begin
                sys <= w_data[2:0];
            end
            if (wr_cnt) begin
                count <= merge16(count, w_data, w_strb);
            end else if (cnt_step) begin
                count <= next_count;
            end
            if (trig_a) begin
                capture_reload_reg_a <= count;
            end else if (wr_ra) begin
                capture_reload_reg_a <= merge16(capture_reload_reg_a, w_data, w_strb);
            end
            if (trig_b) begin
                capture_reload_reg_b <= count;
            end else if (wr_rb) begin
                capture_reload_reg_b <= merge16(capture_reload_reg_b, w_data, w_strb);
            end
            // Alternation restarts at A whenever the timer is not running pulse-width
            if (!is_pwm || !run_or_underflow_flag) begin
                reload_from_b <= 1'b0;
            end else if (underflow) begin
                reload_from_b <= !reload_from_b;
            end
            if (toggle_en && underflow) begin
                pulse_out <= !pulse_out;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------
    assign irq_a = irq_enable_a && (pending_flag_a ||
                   (is_capture && run_or_underflow_flag));
    assign irq_b = irq_enable_b && pending_flag_b;
endmodule

// ---- mmt_properties.sv ----
// Checker: port-level properties of the multi-mode capture timer
`timescale 1ns/1ps
module mmt_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        pulse_out,
    input wire logic        irq_a,
    input wire logic        irq_b,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    // Copy of enables and mode; only software writes these bits
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] sh;
    logic       bq;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wa <= 8'h00;
            wd <= 8'h00;
            sh <= 8'h00;
            bq <= 1'b0;
        end else begin
            bq <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
            if (s_axi_bvalid && !bq && wa == mmt_pkg::ADDR_CTRL) sh <= wd;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        ##[1:2] s_axi_bvalid;
    endsequence
    // The copy lags one edge behind a write, so the write edge itself is excused
    a_write_answer: assert property (wr_taken |-> wr_answer) else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_irq_a_gate: assert property (irq_a |-> sh[mmt_pkg::CTRL_ENA] || $rose(s_axi_bvalid))
        else $error("irq a without enable");
    a_irq_b_gate: assert property (irq_b |-> sh[mmt_pkg::CTRL_ENB] || $rose(s_axi_bvalid))
        else $error("irq b without enable");
    a_pulse_hold: assert property (sh[3:1] != mmt_pkg::MODE_PWM_TOG && !$rose(s_axi_bvalid) |=> $stable(pulse_out))
        else $error("pulse output moved outside toggle mode");
    a_reset_quiet: assert property ($fell(rst) |-> !irq_a && !irq_b && !pulse_out)
        else $error("outputs active after reset");
endmodule
bind multi_mode_timer_capture mmt_checker i_mmt_checker (.ref_clk, .rst, .pulse_out, .irq_a, .irq_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ---- pin_source.sv ----
// Partner model: external signal sources driving the two timer pins
`timescale 1ns/1ps
module pin_source (
    input  wire logic ref_clk,
    input  wire logic set_a,
    input  wire logic set_b,
    output logic      timer_pin_a,
    output logic      timer_pin_b
);
    // Edges launched from the clock, held until the bench asks again
    always @(posedge ref_clk) begin
        timer_pin_a <= set_a;
        timer_pin_b <= set_b;
    end
endmodule

// ---- tb_multi_mode_timer_capture.sv ----
// Testbench: register, capture, event, pulse-width and doze scenarios for the timer
`timescale 1ns/1ps
module tb_multi_mode_timer_capture;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        set_a = 1'b0;
    logic        set_b = 1'b0;
    logic        slow_tick = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        timer_pin_a, timer_pin_b, pulse_out, irq_a, irq_b;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, v, c1;
    int          error_cnt = 0;
    int          checks = 0;

    always #20 ref_clk = ~ref_clk;

    pin_source i_pin_source (.ref_clk, .set_a, .set_b, .timer_pin_a, .timer_pin_b);
    multi_mode_timer_capture i_multi_mode_timer_capture (.ref_clk, .rst, .fast_tick(1'b1), .slow_tick,
        .timer_pin_a, .timer_pin_b, .pulse_out, .irq_a, .irq_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    task automatic test_done;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Valid lines drop once ready is seen, so each call hands over exactly one write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        resp = s_axi_bresp;
        if (n >= 40) begin
            error_cnt++;
            test_done;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        if (n >= 40) begin
            error_cnt++;
            test_done;
        end
    endtask

    task automatic exp_rd(input logic [7:0] a, input logic [31:0] e);
        rd(a, v);
        chk(v, e);
    endtask

    // Synchroniser needs about four edges; eight leaves margin
    task automatic pins(input logic a, input logic b);
        set_a <= a;
        set_b <= b;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic t_regs;
        exp_rd(8'h00, {24'h0, mmt_pkg::CTRL_RESET});
        exp_rd(8'h04, {16'h0, mmt_pkg::COUNT_RESET});
        exp_rd(8'h08, {16'h0, mmt_pkg::RELOAD_RESET});
        exp_rd(8'h10, {24'h0, mmt_pkg::FAST_RESET});
        exp_rd(8'h14, {29'h0, mmt_pkg::SYS_RESET});
        exp_rd(8'h18, 32'h0);
        chk(resp, mmt_pkg::RESP_SLVERR);
        wr(8'h1c, 32'h1);
        chk(resp, mmt_pkg::RESP_SLVERR);
        wr(8'h10, 32'hff);
        exp_rd(8'h10, 32'h83);
    endtask

    task automatic t_capture;
        logic [31:0] ca;
        wr(8'h10, 32'h01);
        wr(8'h00, 32'ha4);
        repeat (4) @(posedge ref_clk);
        exp_rd(8'h00, 32'ha5);
        chk(irq_a, 1'b1);
        wr(8'h00, 32'ha4);
        chk(irq_a, 1'b0);
        pins(1'b1, 1'b0);
        exp_rd(8'h00, 32'hb4);
        chk({irq_a, irq_b}, 2'b10);
        exp_rd(8'h0c, 32'h0);
        rd(8'h08, ca);
        rd(8'h04, v);
        chk(ca[15:8], 8'hff);
        chk(ca > v, 1'b1);
        wr(8'h00, 32'h94);
        chk(irq_a, 1'b0);
    endtask

    task automatic t_edges;
        logic fa;
        logic fb;
        logic [31:0] ca;
        for (int i = 0; i < 4; i++) begin
            fa = i[0];
            fb = i[1];
            pins(fa, fb);
            wr(8'h00, {24'h0, 4'ha, fb, 1'b1, fa, 1'b0});
            pins(!fa, fb);
            exp_rd(8'h00, {24'h0, 4'hb, fb, 1'b1, fa, 1'b0});
            rd(8'h08, ca);
            pins(!fa, !fb);
            exp_rd(8'h00, {24'h0, 4'hf, fb, 1'b1, fa, 1'b0});
            chk(irq_b, 1'b1);
            exp_rd(8'h08, ca);
        end
    endtask

    task automatic t_event;
        wr(8'h00, 32'h20);
        wr(8'h04, 32'h2);
        pins(1'b1, 1'b0);
        exp_rd(8'h04, 32'h2);
        wr(8'h00, 32'h21);
        for (int k = 1; k >= -1; k--) begin
            pins(1'b0, 1'b0);
            pins(1'b1, 1'b0);
            exp_rd(8'h04, {16'h0, 16'(k)});
        end
        exp_rd(8'h00, 32'h31);
        pins(1'b1, 1'b1);
        exp_rd(8'h00, 32'h71);
        wr(8'h00, 32'h23);
        pins(1'b0, 1'b1);
        exp_rd(8'h04, 32'h0000fffe);
    endtask

    task automatic t_pwm;
        logic p;
        wr(8'h00, 32'h00);
        wr(8'h08, 32'h6);
        wr(8'h0c, 32'h1e);
        wr(8'h04, 32'h0);
        wr(8'h00, {28'h0, mmt_pkg::MODE_PWM_TOG, 1'b1});
        for (int k = 0; k < 2; k++) begin
            p = pulse_out;
            for (int n = 0; n < 100 && pulse_out === p; n++) @(posedge ref_clk);
            chk(pulse_out, !p);
            if (pulse_out === p) test_done;
            exp_rd(8'h00, k ? 32'h5b : 32'h1b);
        end
        wr(8'h00, {28'h0, mmt_pkg::MODE_PWM_TOG, 1'b0});
        p = pulse_out;
        rd(8'h04, c1);
        repeat (40) @(posedge ref_clk);
        chk(pulse_out, p);
        exp_rd(8'h04, c1);
    endtask

    task automatic t_doze;
        wr(8'h04, 32'h8000);
        wr(8'h00, 32'ha4);
        pins(1'b0, 1'b0);
        wr(8'h10, 32'h80);
        // Instruction-cycle rate: exactly one step per TC_DIV edges
        rd(8'h04, c1);
        repeat (10 * mmt_pkg::TC_DIV - 2) @(posedge ref_clk);
        rd(8'h04, v);
        chk(c1 - v, 32'h0000000a);
        wr(8'h14, 32'h1);
        rd(8'h04, c1);
        pins(1'b1, 1'b0);
        exp_rd(8'h00, 32'ha4);
        exp_rd(8'h04, c1);
        wr(8'h10, 32'h81);
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        exp_rd(8'h00, 32'hb4);
        rd(8'h04, v);
        chk(v < c1, 1'b1);
        // Low-speed doze: timer follows the slow clock only
        wr(8'h14, 32'h5);
        rd(8'h04, c1);
        repeat (20) @(posedge ref_clk);
        exp_rd(8'h04, c1);
        slow_tick <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rd(8'h04, v);
        chk(v < c1, 1'b1);
        wr(8'h00, 32'h0b);
        rd(8'h04, c1);
        repeat (20) @(posedge ref_clk);
        exp_rd(8'h04, c1);
        wr(8'h10, 32'h01);
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_regs;
        t_capture;
        t_edges;
        t_event;
        t_pwm;
        t_doze;
        test_done;
    end
endmodule
